// >>> lcd_host_access_sync.sv
// Host port, display memory sequencing, panel timing and APB registers
//
// The implementer's own choices: the APB slave port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module lcd_host_access_sync #(
  parameter int TEXT_ROWS = 8,
  parameter int LINES = 64
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cs_n_i,
  input wire logic register_select_i,
  input wire logic rd_n_i,
  input wire logic wr_n_i,
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  output logic [15:0] vram_addr_o,
  output logic [7:0] vram_wdata_o,
  input wire logic [7:0] vram_rdata_i,
  output logic vram_we_o,
  output logic vram_oe_o,
  output logic panel_shift_clock_o,
  output logic line_latch_pulse_o,
  output logic frame_alternation_signal_o,
  output logic retrace_status_bit_o,
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o
);
  localparam int LW = $clog2(LINES);

  lcd_host_pkg::host_pins_t pins_s1_reg, pins_s2_reg, pins_prev_reg;
  lcd_host_pkg::mode_t mode_reg;
  logic [7:0] data_s1_reg, data_s2_reg;
  logic sleep_reg, param_idx_reg;
  logic wr_pend_reg, rd_pend_reg, busy_reg, op_wr_reg;
  logic [7:0] wr_buf_reg, rbuf_reg;
  logic [15:0] cursor_reg, step_reg, refresh_addr_reg;
  logic [3:0] phase_reg;
  logic [7:0] char_reg, char_next;
  logic [LW-1:0] line_reg;
  logic retrace_reg;
  logic [31:0] ctrl_reg, probe_reg, rd_mux;
  logic [7:0] cr_w, tcr_w;
  logic [4:0] fx_w, pitch_w;
  logic wr_done, rd_done, cmd_wr, dat_wr, cmd_ok;
  logic host_issue, host_done, refresh_en, two_bytes, apb_acc, mapped;
  logic [7:0] status_byte;
  logic [3:0] probe_col;

  assign cr_w = ctrl_reg[lcd_host_pkg::CR_LSB +: 8];
  assign tcr_w = ctrl_reg[lcd_host_pkg::TCR_LSB +: 8];
  assign fx_w = ctrl_reg[lcd_host_pkg::FX_LSB +: 5];
  assign pitch_w = ctrl_reg[lcd_host_pkg::PITCH_LSB +: 5];

  // Pin synchronisers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pins_s1_reg <= lcd_host_pkg::PINS_IDLE;
      pins_s2_reg <= lcd_host_pkg::PINS_IDLE;
      pins_prev_reg <= lcd_host_pkg::PINS_IDLE;
      data_s1_reg <= 8'h00;
      data_s2_reg <= 8'h00;
    end else begin
      pins_s1_reg <= {cs_n_i, register_select_i, rd_n_i, wr_n_i};
      pins_s2_reg <= pins_s1_reg;
      pins_prev_reg <= pins_s2_reg;
      data_s1_reg <= data_i;
      data_s2_reg <= data_s1_reg;
    end
  end

  // Strobe edges
  assign wr_done = !pins_prev_reg.cs_n && !pins_prev_reg.wr_n && pins_s2_reg.wr_n;
  assign rd_done = !pins_prev_reg.cs_n && pins_prev_reg.rs && !pins_prev_reg.rd_n &&
                   pins_s2_reg.rd_n;
  assign cmd_wr = wr_done && pins_prev_reg.rs;
  assign dat_wr = wr_done && !pins_prev_reg.rs;
  assign cmd_ok = !sleep_reg || data_s2_reg == lcd_host_pkg::CMD_SYSTEM_SET ||
                  data_s2_reg == lcd_host_pkg::CMD_SLEEP_IN;

  // Command decode
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mode_reg <= lcd_host_pkg::MODE_IDLE;
      sleep_reg <= 1'b0;
      param_idx_reg <= 1'b0;
    end else if (cmd_wr && cmd_ok) begin
      param_idx_reg <= 1'b0;
      unique case (data_s2_reg)
        lcd_host_pkg::CMD_SYSTEM_SET: begin
          mode_reg <= lcd_host_pkg::MODE_SYSSET;
          sleep_reg <= 1'b0;
        end
        lcd_host_pkg::CMD_SLEEP_IN: begin
          mode_reg <= lcd_host_pkg::MODE_IDLE;
          sleep_reg <= 1'b1;
        end
        lcd_host_pkg::CMD_CURSOR_WRITE: mode_reg <= lcd_host_pkg::MODE_CSRW;
        lcd_host_pkg::CMD_CURSOR_DIR: mode_reg <= lcd_host_pkg::MODE_DIR;
        lcd_host_pkg::CMD_MEMORY_WRITE: mode_reg <= lcd_host_pkg::MODE_WRITE;
        lcd_host_pkg::CMD_MEMORY_READ: mode_reg <= lcd_host_pkg::MODE_READ;
        default: mode_reg <= lcd_host_pkg::MODE_IDLE;
      endcase
    end else if (dat_wr) begin
      param_idx_reg <= 1'b1;
    end
  end

  // Pending host accesses, set wins over issue
  assign host_issue = phase_reg == lcd_host_pkg::SLOT_HOST && (wr_pend_reg || rd_pend_reg);
  assign host_done = busy_reg && phase_reg == lcd_host_pkg::HOST_DONE;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      wr_buf_reg <= 8'h00;
    end else begin
      wr_pend_reg <= (wr_pend_reg && !host_issue) ||
                     (dat_wr && mode_reg == lcd_host_pkg::MODE_WRITE);
      rd_pend_reg <= (rd_pend_reg && !(host_issue && !wr_pend_reg)) ||
                     (cmd_wr && cmd_ok && data_s2_reg == lcd_host_pkg::CMD_MEMORY_READ) ||
                     (rd_done && mode_reg == lcd_host_pkg::MODE_READ);
      if (dat_wr && mode_reg == lcd_host_pkg::MODE_WRITE) begin
        wr_buf_reg <= data_s2_reg;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      busy_reg <= 1'b0;
      op_wr_reg <= 1'b0;
      rbuf_reg <= 8'h00;
    end else begin
      if (host_issue) begin
        busy_reg <= 1'b1;
        op_wr_reg <= wr_pend_reg;
      end else if (host_done) begin
        busy_reg <= 1'b0;
      end
      if (host_done && !op_wr_reg) begin
        rbuf_reg <= vram_rdata_i;
      end
    end
  end

  // Cursor address and step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cursor_reg <= 16'h0000;
      step_reg <= lcd_host_pkg::STEP_RESET;
    end else begin
      if (dat_wr && mode_reg == lcd_host_pkg::MODE_CSRW) begin
        if (param_idx_reg) begin
          cursor_reg[15:8] <= data_s2_reg;
        end else begin
          cursor_reg[7:0] <= data_s2_reg;
        end
      end else if (host_done) begin
        cursor_reg <= cursor_reg + step_reg;
      end
      if (dat_wr && mode_reg == lcd_host_pkg::MODE_DIR) begin
        step_reg <= {{8{data_s2_reg[7]}}, data_s2_reg};
      end
    end
  end

  // Memory cycle and line timing
  assign char_next = (char_reg == tcr_w) ? 8'h00 : char_reg + 8'h01;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phase_reg <= 4'h0;
      char_reg <= 8'h00;
      line_reg <= '0;
      retrace_reg <= 1'b0;
    end else begin
      phase_reg <= (phase_reg == lcd_host_pkg::PHASE_LAST) ? 4'h0 : phase_reg + 4'h1;
      if (phase_reg == lcd_host_pkg::PHASE_LAST) begin
        char_reg <= char_next;
        retrace_reg <= char_next > cr_w;
        if (char_next == 8'h00) begin
          line_reg <= (line_reg == LW'(LINES - 1)) ? '0 : line_reg + LW'(1);
        end
      end
    end
  end

  // Panel drive, held low in reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      panel_shift_clock_o <= 1'b0;
      line_latch_pulse_o <= 1'b0;
      frame_alternation_signal_o <= 1'b0;
    end else begin
      panel_shift_clock_o <= phase_reg < lcd_host_pkg::SHIFT_HIGH_END;
      if (phase_reg == lcd_host_pkg::PHASE_LAST) begin
        line_latch_pulse_o <= char_next == cr_w + 8'h01;
        if (char_next == 8'h00 && line_reg == LW'(LINES - 1)) begin
          frame_alternation_signal_o <= !frame_alternation_signal_o;
        end
      end
    end
  end

  // Display memory bus
  assign refresh_en = !retrace_reg && !sleep_reg;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      vram_addr_o <= 16'h0000;
      vram_wdata_o <= 8'h00;
      vram_we_o <= 1'b0;
      vram_oe_o <= 1'b0;
      refresh_addr_reg <= 16'h0000;
    end else if (phase_reg == lcd_host_pkg::SLOT_REFRESH) begin
      vram_addr_o <= refresh_addr_reg;
      vram_oe_o <= refresh_en;
      vram_we_o <= 1'b0;
      if (char_reg == 8'h00 && line_reg == '0) begin
        refresh_addr_reg <= 16'h0001;
      end else if (refresh_en) begin
        refresh_addr_reg <= refresh_addr_reg + 16'h0001;
      end
    end else if (phase_reg == lcd_host_pkg::SLOT_HOST) begin
      vram_addr_o <= cursor_reg;
      vram_wdata_o <= wr_buf_reg;
      vram_we_o <= host_issue && wr_pend_reg;
      vram_oe_o <= host_issue && !wr_pend_reg;
    end else if (phase_reg == lcd_host_pkg::SLOT_IDLE) begin
      vram_we_o <= 1'b0;
      vram_oe_o <= 1'b0;
    end
  end

  // Host read data and status
  always_comb begin
    status_byte = 8'h00;
    status_byte[lcd_host_pkg::STATUS_BIT] = retrace_reg;
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      data_o <= 8'h00;
      data_oe_o <= 1'b0;
      retrace_status_bit_o <= 1'b0;
    end else begin
      data_oe_o <= !pins_s2_reg.cs_n && !pins_s2_reg.rd_n;
      data_o <= pins_s2_reg.rs ? rbuf_reg : status_byte;
      retrace_status_bit_o <= retrace_reg;
    end
  end

  // Bitmap layout and memory sizing
  assign two_bytes = fx_w > lcd_host_pkg::ONE_BYTE_PIXELS ||
                     pitch_w > lcd_host_pkg::ONE_BYTE_PIXELS;
  assign probe_col = probe_reg[lcd_host_pkg::PROBE_COL_LSB +: 4];
  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr_i)
      lcd_host_pkg::ADDR_CTRL: rd_mux = ctrl_reg;
      lcd_host_pkg::ADDR_STATUS: begin
        rd_mux[lcd_host_pkg::ST_RETRACE] = retrace_reg;
        rd_mux[lcd_host_pkg::ST_SLEEP] = sleep_reg;
        rd_mux[lcd_host_pkg::ST_TWO_BYTES] = two_bytes;
        rd_mux[lcd_host_pkg::ST_MODE_LSB +: 6] = mode_reg;
      end
      lcd_host_pkg::ADDR_CURSOR: rd_mux[15:0] = cursor_reg;
      lcd_host_pkg::ADDR_SCREEN: begin
        rd_mux = (32'(cr_w) + 32'h1) * 32'(TEXT_ROWS);
        if (ctrl_reg[lcd_host_pkg::GFX_BIT]) begin
          rd_mux = rd_mux << lcd_host_pkg::GFX_SHIFT;
        end
      end
      lcd_host_pkg::ADDR_PROBE: begin
        rd_mux = probe_reg;
        rd_mux[lcd_host_pkg::PROBE_PIX_BIT] = probe_reg[4'hf - probe_col];
      end
      default: mapped = 1'b0;
    endcase
  end

  // APB slave, one wait state
  assign apb_acc = psel_i && penable_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pready_o <= 1'b0;
      prdata_o <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o <= apb_acc && !pready_o;
      if (apb_acc && !pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rd_mux;
        pslverr_o <= !mapped;
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_reg <= lcd_host_pkg::CTRL_RESET;
      probe_reg <= 32'h0000_0000;
    end else if (apb_acc && pready_o && pwrite_i) begin
      if (paddr_i == lcd_host_pkg::ADDR_CTRL) begin
        ctrl_reg <= pwdata_i;
      end
      if (paddr_i == lcd_host_pkg::ADDR_PROBE) begin
        probe_reg <= {12'h000, pwdata_i[19:0]};
      end
    end
  end

  // Assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_status_read;
    (!pins_s2_reg.cs_n && !pins_s2_reg.rd_n && !pins_s2_reg.rs) |=>
      (data_oe_o && data_o[lcd_host_pkg::STATUS_BIT] == $past(retrace_reg));
  endproperty
  a_status_read: assert property (p_status_read) else $error("status bit not driven");
  property p_fetch_active;
    (phase_reg == lcd_host_pkg::SLOT_REFRESH && !retrace_reg && !sleep_reg) |=> vram_oe_o;
  endproperty
  a_fetch_active: assert property (p_fetch_active) else $error("no fetch when active");
  property p_no_fetch_retrace;
    (phase_reg == lcd_host_pkg::SLOT_REFRESH && retrace_reg) |=> !vram_oe_o;
  endproperty
  a_no_fetch_retrace: assert property (p_no_fetch_retrace) else $error("fetch in retrace");
  property p_cycle_nine;
    (phase_reg == lcd_host_pkg::SLOT_REFRESH) |-> ##9 (phase_reg == lcd_host_pkg::SLOT_REFRESH);
  endproperty
  a_cycle_nine: assert property (p_cycle_nine) else $error("cycle not nine clocks");
  property p_addr_rate;
    $changed(vram_addr_o) |-> ($past(phase_reg) == lcd_host_pkg::SLOT_REFRESH ||
                               $past(phase_reg) == lcd_host_pkg::SLOT_HOST);
  endproperty
  a_addr_rate: assert property (p_addr_rate) else $error("address moved off slot");
  property p_reset_halt;
    disable iff (1'b0) rst_i |=> (!panel_shift_clock_o && !line_latch_pulse_o &&
                                  !frame_alternation_signal_o);
  endproperty
  a_reset_halt: assert property (p_reset_halt) else $error("panel drive in reset");
  property p_write_store;
    (dat_wr && mode_reg == lcd_host_pkg::MODE_WRITE) |-> ##[1:20] vram_we_o;
  endproperty
  a_write_store: assert property (p_write_store) else $error("data byte not stored");
  property p_read_prefetch;
    (rd_done && mode_reg == lcd_host_pkg::MODE_READ) |-> ##[1:20] (host_done && !op_wr_reg);
  endproperty
  a_read_prefetch: assert property (p_read_prefetch) else $error("no prefetch");
  property p_sleep_ignore;
    (cmd_wr && sleep_reg && data_s2_reg != lcd_host_pkg::CMD_SYSTEM_SET &&
     data_s2_reg != lcd_host_pkg::CMD_SLEEP_IN) |=> (mode_reg == $past(mode_reg));
  endproperty
  a_sleep_ignore: assert property (p_sleep_ignore) else $error("command taken asleep");
  property p_advance;
    (host_done && !(dat_wr && mode_reg == lcd_host_pkg::MODE_CSRW)) |=>
      (cursor_reg == $past(cursor_reg) + $past(step_reg));
  endproperty
  a_advance: assert property (p_advance) else $error("cursor did not advance");
  c_status_read: cover property (p_status_read);
  c_write: cover property ((dat_wr && mode_reg == lcd_host_pkg::MODE_WRITE) ##[1:20] vram_we_o);
  c_read: cover property (rd_done && mode_reg == lcd_host_pkg::MODE_READ);
endmodule
`default_nettype wire

// >>> lcd_host_access_sync_test.sv
// Self-checking bench for the LCD host access block
`timescale 1ns/1ps
`default_nettype none
module lcd_host_access_sync_test;
  localparam int ROWS = 8;
  // Start-up settling, 3 ms at 50 ns
  localparam int STABLE_CYC = 60000;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic psel_i = 1'b0;
  logic penable_i = 1'b0;
  logic pwrite_i = 1'b0;
  logic [7:0] paddr_i = 8'h00;
  logic [31:0] pwdata_i = 32'h0;
  logic [7:0] vram_rdata_i = 8'h00;
  lcd_host_pkg::host_pins_t pins;
  logic [7:0] hdata, data_o, vram_wdata_o;
  logic [15:0] vram_addr_o;
  logic data_oe_o, vram_we_o, vram_oe_o, sclk, latch, frame, status;
  logic [31:0] prdata_o;
  logic pready_o, pslverr_o, mon_on = 1'b0;
  logic [7:0] mem [256];
  int error_cnt = 0;
  int cmp_count = 0;
  int seed = 32'h6649;
  int cr, tcr, hi_run = 0, lp_run = 0;
  always #25 clk_i = ~clk_i;
  lcd_host_access_sync #(.TEXT_ROWS(ROWS), .LINES(64)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .cs_n_i(pins.cs_n), .register_select_i(pins.rs),
    .rd_n_i(pins.rd_n), .wr_n_i(pins.wr_n), .data_i(hdata), .data_o(data_o),
    .data_oe_o(data_oe_o), .vram_addr_o(vram_addr_o), .vram_wdata_o(vram_wdata_o),
    .vram_rdata_i(vram_rdata_i), .vram_we_o(vram_we_o), .vram_oe_o(vram_oe_o),
    .panel_shift_clock_o(sclk), .line_latch_pulse_o(latch),
    .frame_alternation_signal_o(frame), .retrace_status_bit_o(status),
    .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o));
  lcd_host_model u_host (.clk_i(clk_i), .line_latch_pulse_i(latch), .data_i(data_o),
    .data_oe_i(data_oe_o), .pins_o(pins), .data_o(hdata));
  initial foreach (mem[i]) mem[i] = 8'(i);
  // Display memory; released data bus shows a changing pattern
  always @(posedge clk_i) begin
    if (vram_we_o === 1'b1) mem[vram_addr_o[7:0]] <= vram_wdata_o;
    vram_rdata_i <= (vram_oe_o === 1'b1) ? mem[vram_addr_o[7:0]] : ~vram_rdata_i;
  end
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected %s: expected %h, seen %h", nm, exp, got);
    end
  endtask
  // Retrace and latch length monitor
  always @(posedge clk_i) begin
    hi_run <= (status === 1'b1) ? hi_run + 1 : 0;
    lp_run <= (latch === 1'b1) ? lp_run + 1 : 0;
    if (mon_on && status !== 1'b1 && hi_run != 0) chk("retrace_len", ret_len(), hi_run);
    if (mon_on && latch !== 1'b1 && lp_run != 0) chk("latch_len", 9, lp_run);
    if (mon_on && status === 1'b1) chk("oe_in_retrace", 0, vram_oe_o);
  end
  function automatic int ret_len();
    return (tcr - cr) * 9;
  endfunction
  function automatic logic [31:0] ctrl_w(int c, int t, int f, int p, int g);
    return 32'((g << 29) | (p << 24) | (f << 16) | (t << 8) | c);
  endfunction
  function automatic logic [31:0] mode_of(logic [7:0] c);
    case (c)
      lcd_host_pkg::CMD_CURSOR_WRITE: return 32'(lcd_host_pkg::MODE_CSRW) << 8;
      lcd_host_pkg::CMD_CURSOR_DIR: return 32'(lcd_host_pkg::MODE_DIR) << 8;
      lcd_host_pkg::CMD_MEMORY_WRITE: return 32'(lcd_host_pkg::MODE_WRITE) << 8;
      lcd_host_pkg::CMD_MEMORY_READ: return 32'(lcd_host_pkg::MODE_READ) << 8;
      default: return 32'(lcd_host_pkg::MODE_IDLE) << 8;
    endcase
  endfunction
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    int n;
    n = 0;
    @(posedge clk_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_i);
    penable_i <= 1'b1;
    do begin
      @(posedge clk_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    q = prdata_o;
    e = pslverr_o;
    if (n >= 50) begin
      error_cnt++;
      conclude();
    end
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] m,
                        input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, exp, q & m);
  endtask
  task automatic cmd(input logic [7:0] c);
    logic [7:0] q;
    u_host.strobe(1'b1, 1'b0, c, q);
  endtask
  task automatic par(input logic [7:0] p);
    logic [7:0] q;
    u_host.strobe(1'b0, 1'b0, p, q);
  endtask
  task automatic tdone(input string s);
    $display("test %s finished", s);
  endtask
  task automatic conclude();
    chk("host_waits", 0, u_host.fails);
    $display("counts: %0d compared, %0d mismatched", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (90000) @(posedge clk_i);
    error_cnt++;
    conclude();
  end
  initial begin
    logic [31:0] q, m0, pw;
    logic [7:0] b, eb [6];
    logic [15:0] st;
    logic e;
    int n, f, p;
    @(negedge clk_i);
    chk("panel_in_reset", 3'b000, {sclk, latch, frame});
    @(posedge clk_i);
    rst_i <= 1'b0;
    rd_chk("ctrl_reset", lcd_host_pkg::ADDR_CTRL, '1, lcd_host_pkg::CTRL_RESET);
    for (int i = 0; i < 5; i++) begin
      cr = $unsigned($random(seed)) % 8;
      f = (i == 1) ? 9 : (i == 4) ? 16 : 8;
      p = (i == 2) ? 9 : 8;
      wr(lcd_host_pkg::ADDR_CTRL, ctrl_w(cr, cr + 12, f, p, int'(i == 3)));
      rd_chk("two_byte", lcd_host_pkg::ADDR_STATUS, 4, (f > 8 || p > 8) ? 4 : 0);
      rd_chk("screen", lcd_host_pkg::ADDR_SCREEN, '1, ((cr + 1) * ROWS) << (3 * (i == 3)));
    end
    for (int i = 0; i < 4; i++) begin
      pw = $random(seed);
      wr(lcd_host_pkg::ADDR_PROBE, pw);
      rd_chk("probe_row", lcd_host_pkg::ADDR_PROBE, 32'h7fff_ffff, pw & 32'h000f_ffff);
      rd_chk("probe_pixel", lcd_host_pkg::ADDR_PROBE, 32'h8000_0000,
             {pw[15 - int'(pw[19:16])], 31'h0});
    end
    apb(1'b0, 8'h14, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    tdone("registers");
    cr = 1 + $unsigned($random(seed)) % 6;
    tcr = cr + 16 + $unsigned($random(seed)) % 3;
    wr(lcd_host_pkg::ADDR_CTRL, ctrl_w(cr, tcr, 8, 8, 0));
    u_host.wait_window();
    u_host.wait_window();
    mon_on <= 1'b1;
    u_host.wait_window();
    u_host.strobe(1'b0, 1'b1, 8'h00, b);
    chk("status_high", 1, b[lcd_host_pkg::STATUS_BIT]);
    n = 0;
    while (status !== 1'b0 && n < 500) begin
      @(posedge clk_i);
      n++;
    end
    u_host.strobe(1'b0, 1'b1, 8'h00, b);
    chk("status_low", 0, b[lcd_host_pkg::STATUS_BIT]);
    u_host.wait_window();
    mon_on <= 1'b0;
    tdone("status");
    st = {8'h00, 2'b01, 6'($random(seed))};
    cmd(lcd_host_pkg::CMD_CURSOR_DIR);
    par(8'h02);
    cmd(lcd_host_pkg::CMD_CURSOR_WRITE);
    par(st[7:0]);
    par(st[15:8]);
    cmd(lcd_host_pkg::CMD_MEMORY_WRITE);
    for (int i = 0; i < 6; i++) begin
      eb[i] = 8'($random(seed));
      u_host.wait_window();
      par(eb[i]);
    end
    u_host.idle(20);
    for (int i = 0; i < 6; i++) chk("vram_byte", eb[i], mem[8'(st + 2 * i)]);
    rd_chk("cursor", lcd_host_pkg::ADDR_CURSOR, 32'hffff, st + 12);
    tdone("memory_write");
    cmd(lcd_host_pkg::CMD_CURSOR_WRITE);
    par(st[7:0]);
    par(st[15:8]);
    cmd(lcd_host_pkg::CMD_MEMORY_READ);
    for (int i = 0; i < 6; i++) begin
      u_host.strobe(1'b1, 1'b1, 8'h00, b);
      chk("read_byte", eb[i], b);
    end
    foreach (eb[i]) eb[i] = 8'h42 + 8'(i);
    eb[4] = 8'h7f;
    for (int i = 0; i < 5; i++) begin
      cmd(eb[i]);
      rd_chk("mode", lcd_host_pkg::ADDR_STATUS, 32'h3f00, mode_of(eb[i]));
    end
    tdone("memory_read");
    cmd(lcd_host_pkg::CMD_SLEEP_IN);
    rd_chk("sleep", lcd_host_pkg::ADDR_STATUS, 2, 2);
    apb(1'b0, lcd_host_pkg::ADDR_STATUS, 32'h0, m0, e);
    cmd(lcd_host_pkg::CMD_CURSOR_WRITE);
    rd_chk("sleep_ignore", lcd_host_pkg::ADDR_STATUS, 32'h3f00, m0 & 32'h3f00);
    cmd(lcd_host_pkg::CMD_SYSTEM_SET);
    rd_chk("sleep_setup", lcd_host_pkg::ADDR_STATUS, 32'h3f00,
           32'(lcd_host_pkg::MODE_SYSSET) << 8);
    tdone("sleep");
    cmd(lcd_host_pkg::CMD_SLEEP_IN);
    @(posedge clk_i);
    rst_i <= 1'b1;
    cmd(lcd_host_pkg::CMD_MEMORY_WRITE);
    repeat (10) @(posedge clk_i);
    @(negedge clk_i);
    chk("panel_in_reset", 3'b000, {sclk, latch, frame});
    @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (STABLE_CYC) @(posedge clk_i);
    rd_chk("sleep_cleared", lcd_host_pkg::ADDR_STATUS, 2, 0);
    rd_chk("reset_mode", lcd_host_pkg::ADDR_STATUS, 32'h3f00,
           32'(lcd_host_pkg::MODE_IDLE) << 8);
    tdone("reset");
    conclude();
  end
endmodule
`default_nettype wire

// >>> lcd_host_model.sv
// Host microprocessor model for the parallel port
`timescale 1ns/1ps
`default_nettype none
module lcd_host_model (
  input wire logic clk_i,
  input wire logic line_latch_pulse_i,
  input wire logic [7:0] data_i,
  input wire logic data_oe_i,
  output var lcd_host_pkg::host_pins_t pins_o,
  output logic [7:0] data_o
);
  int fails = 0;
  initial begin
    pins_o = lcd_host_pkg::PINS_IDLE;
    data_o = 8'h00;
  end
  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // One strobe; rd selects read, rs the register select
  task automatic strobe(input logic rs, input logic rd, input logic [7:0] d,
                        output logic [7:0] q);
    @(posedge clk_i);
    pins_o <= '{cs_n: 1'b0, rs: rs, rd_n: ~rd, wr_n: rd};
    data_o <= d;
    idle(5);
    q = data_i;
    if (rd && data_oe_i !== 1'b1) fails++;
    pins_o <= '{cs_n: 1'b0, rs: rs, rd_n: 1'b1, wr_n: 1'b1};
    idle(4);
    pins_o <= '{cs_n: 1'b1, rs: rs, rd_n: 1'b1, wr_n: 1'b1};
    data_o <= ~d;
    idle(8);
  endtask
  // Wait for latch fall, then until 5x9 periods after its rise
  task automatic wait_window();
    int n;
    n = 0;
    while (line_latch_pulse_i !== 1'b1 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    while (line_latch_pulse_i !== 1'b0 && n < 3000) begin
      @(posedge clk_i);
      n++;
    end
    if (n >= 3000) fails++;
    idle(35);
  endtask
endmodule
`default_nettype wire

// >>> lcd_host_pkg.sv
// Constants and types for the LCD host access and synchronisation block
//
// Summary of operation
// - Host access takes the next host slot; a read pending with a write waits one cycle more
// - Status read drives the status data bit
// - Status high in retrace, low during fetch
// - No display reads during end-of-line retrace
// - Only setup and sleep commands while asleep
// - Memory-write command, then data bytes stored
// - Memory-read command prefetches first byte
// - Each data read prefetches next byte
// - Commands ignored while reset is asserted
// - Panel drive outputs halted during reset
// - Bitmap origin top-left, bits horizontally adjacent
// - Field width up to 16, two-byte rows
// - No spacing; wide pitch needs two bytes
// - Graphics screen takes eight times text memory
// - Memory lines toggle at one third rate
// - Read select low status, high data
// - Write select low data, high command
// - Refresh read cycle lasts nine periods
// - Cursor advances by step after access
package lcd_host_pkg;
  localparam logic [3:0] PHASE_LAST = 4'h8;
  localparam logic [3:0] SLOT_REFRESH = 4'h0;
  localparam logic [3:0] SLOT_HOST = 4'h3;
  localparam logic [3:0] HOST_DONE = 4'h5;
  localparam logic [3:0] SLOT_IDLE = 4'h6;
  localparam logic [3:0] SHIFT_HIGH_END = 4'h4;
  localparam int STATUS_BIT = 6;
  localparam logic [7:0] CMD_SYSTEM_SET = 8'h40;
  localparam logic [7:0] CMD_SLEEP_IN = 8'h41;
  localparam logic [7:0] CMD_CURSOR_WRITE = 8'h42;
  localparam logic [7:0] CMD_CURSOR_DIR = 8'h43;
  localparam logic [7:0] CMD_MEMORY_WRITE = 8'h44;
  localparam logic [7:0] CMD_MEMORY_READ = 8'h45;
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_CURSOR = 8'h08;
  localparam logic [7:0] ADDR_SCREEN = 8'h0c;
  localparam logic [7:0] ADDR_PROBE = 8'h10;
  localparam int CR_LSB = 0;
  localparam int TCR_LSB = 8;
  localparam int FX_LSB = 16;
  localparam int PITCH_LSB = 24;
  localparam int GFX_BIT = 29;
  localparam logic [31:0] CTRL_RESET = 32'h0808_2f27;
  localparam int ST_RETRACE = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_TWO_BYTES = 2;
  localparam int ST_MODE_LSB = 8;
  localparam int PROBE_COL_LSB = 16;
  localparam int PROBE_PIX_BIT = 31;
  localparam logic [4:0] ONE_BYTE_PIXELS = 5'h08;
  localparam int GFX_SHIFT = 3;
  localparam logic [15:0] STEP_RESET = 16'h0001;
  typedef struct packed {
    logic cs_n;
    logic rs;
    logic rd_n;
    logic wr_n;
  } host_pins_t;
  localparam host_pins_t PINS_IDLE = 4'hb;
  typedef enum logic [5:0] {
    MODE_IDLE = 6'b000001,
    MODE_WRITE = 6'b000010,
    MODE_READ = 6'b000100,
    MODE_CSRW = 6'b001000,
    MODE_DIR = 6'b010000,
    MODE_SYSSET = 6'b100000
  } mode_t;
endpackage
